/* File: design/wdu_top.sv */
// Watchdog unit: 8-bit time-out counter, keyed control access, reset flag.
// Assumes a single-cycle register port master and that chip_reset_req
// is fed to the chip reset controller; rst is the external/power-on reset.
`timescale 1ns/1ps
`include "wdu_map.svh"

module wdu_top (
    input  wire logic                  ref_clk,             // 50 MHz always-on clock
    input  wire logic                  rst,                 // External/power-on reset
    input  wire logic                  config_disable_bit,  // Nonvolatile disable strap
    input  wire wdu_pkg::wdu_bus_req_t bus_req,             // Register port request
    output logic [7:0]                 rdata,               // Read data, cycle after
    output logic                       chip_reset_req,      // Chip reset request
    output logic                       wd_running,          // Counter is active
    output logic                       irq                  // Level interrupt
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    wdu_pkg::wdu_ctrl_t       ctrl_ff;
    wdu_pkg::wdu_key_state_t  key_ff;
    logic [7:0]               cnt_ff;
    logic                     flag_ff;
    logic                     cfg_dis_ff;
    logic                     cfg_loaded_ff;
    logic [3:0]               rst_cnt_ff;
    logic [`WDU_IRQ_W-1:0]    irq_stat_ff;
    logic [`WDU_IRQ_W-1:0]    irq_mask_ff;
    logic [`WDU_IRQ_W-1:0]    nxt_irq_stat;
    logic [`WDU_IRQ_W-1:0]    irq_evt;
    logic [7:0]               nxt_rdata;
    logic                     counter_tick;
    logic                     running;
    logic                     overflow;
    logic                     refresh_hit;
    logic                     key_wr;
    logic                     key_err;
    logic                     ctrl_wr;

    // Write strobe decode used at several places
    function automatic logic wr_at(input wdu_pkg::wdu_bus_req_t r, input logic [7:0] a);
        wr_at = r.we && (r.addr == a);
    endfunction : wr_at

    // ------------------------------------------------------------------------
    // Time base
    // ------------------------------------------------------------------------
    wdu_prescaler u_prescaler (
        .ref_clk      (ref_clk),
        .rst          (rst),
        .sel          (ctrl_ff.sel),
        .restart      (refresh_hit || !running || overflow),
        .counter_tick (counter_tick)
    );

    // ------------------------------------------------------------------------
    // Decode and status terms
    // ------------------------------------------------------------------------
    // Strap blocks the counter whatever the enable bit says
    assign running     = ctrl_ff.sw_en && cfg_loaded_ff && !cfg_dis_ff;
    assign overflow    = running && counter_tick && (cnt_ff == `WDU_CNT_MAX);
    assign refresh_hit = wr_at(bus_req, `WDU_ADDR_REFRESH_KEY)
                         && (bus_req.wdata == `WDU_REFRESH_KEY);
    assign key_wr      = wr_at(bus_req, `WDU_ADDR_ACCESS_KEY);
    assign ctrl_wr     = wr_at(bus_req, `WDU_ADDR_CONTROL);
    assign key_err     = key_wr && (key_ff != wdu_pkg::KEY_OPEN)
                         && !((key_ff == wdu_pkg::KEY_IDLE
                               && bus_req.wdata == `WDU_KEY_FIRST)
                           || (key_ff == wdu_pkg::KEY_GOT_FIRST
                               && bus_req.wdata == `WDU_KEY_SECOND)
                           || (key_ff == wdu_pkg::KEY_GOT_SECOND
                               && bus_req.wdata == `WDU_KEY_THIRD));

    // ------------------------------------------------------------------------
    // Configuration strap capture
    // ------------------------------------------------------------------------
    // Sampled on the first edge after any reset release
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            cfg_loaded_ff <= 1'b0;
            cfg_dis_ff    <= 1'b0;
        end
        else if (overflow)
            cfg_loaded_ff <= 1'b0;  // Watchdog reset resamples
        else if (!cfg_loaded_ff)
        begin
            cfg_loaded_ff <= 1'b1;
            cfg_dis_ff    <= config_disable_bit;
        end
    end

    // ------------------------------------------------------------------------
    // Time-out counter
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            cnt_ff <= `WDU_ZERO8;
        else if (overflow || refresh_hit || !running)
            cnt_ff <= `WDU_ZERO8;  // Refresh restarts from zero
        else if (counter_tick)
            cnt_ff <= cnt_ff + 8'h01;  // 256 ticks to time-out
    end

    // ------------------------------------------------------------------------
    // Unlock key sequence
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            key_ff <= wdu_pkg::KEY_IDLE;
        else if (overflow)
            key_ff <= wdu_pkg::KEY_IDLE;
        else if (ctrl_wr && key_ff == wdu_pkg::KEY_OPEN)
            key_ff <= wdu_pkg::KEY_IDLE;  // One control write per unlock
        else if (key_wr)
        begin
            unique case (key_ff)
                wdu_pkg::KEY_IDLE:
                    key_ff <= (bus_req.wdata == `WDU_KEY_FIRST)
                              ? wdu_pkg::KEY_GOT_FIRST : wdu_pkg::KEY_IDLE;
                wdu_pkg::KEY_GOT_FIRST:
                    key_ff <= (bus_req.wdata == `WDU_KEY_SECOND) ? wdu_pkg::KEY_GOT_SECOND
                              : (bus_req.wdata == `WDU_KEY_FIRST)
                              ? wdu_pkg::KEY_GOT_FIRST : wdu_pkg::KEY_IDLE;
                wdu_pkg::KEY_GOT_SECOND:
                    key_ff <= (bus_req.wdata == `WDU_KEY_THIRD) ? wdu_pkg::KEY_OPEN
                              : (bus_req.wdata == `WDU_KEY_FIRST)
                              ? wdu_pkg::KEY_GOT_FIRST : wdu_pkg::KEY_IDLE;
                wdu_pkg::KEY_OPEN:
                    key_ff <= wdu_pkg::KEY_OPEN;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_ff.sw_en <= 1'b0;
            ctrl_ff.sel   <= `WDU_SEL_RESET;
        end
        else if (overflow)
        begin
            ctrl_ff.sw_en <= 1'b0;           // Watchdog reset clears enable
            ctrl_ff.sel   <= `WDU_SEL_RESET;
        end
        else if (ctrl_wr && key_ff == wdu_pkg::KEY_OPEN)
        begin
            // A started watchdog keeps its enable
            ctrl_ff.sw_en <= bus_req.wdata[`WDU_CTRL_EN_BIT] || running;
            ctrl_ff.sel   <= bus_req.wdata[3:0];
        end
    end

    // ------------------------------------------------------------------------
    // Watchdog reset flag
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            flag_ff <= 1'b0;  // External/power-on reset clears
        else if (overflow)
            flag_ff <= 1'b1;  // Set wins over clear
        else if (wr_at(bus_req, `WDU_ADDR_RESET_CAUSE)
                 && bus_req.wdata[`WDU_CAUSE_FLAG_BIT])
            flag_ff <= 1'b0;  // Software clear
    end

    // ------------------------------------------------------------------------
    // Chip reset request stretch
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            rst_cnt_ff <= 4'h0;
        else if (overflow)
            rst_cnt_ff <= `WDU_RST_CYCLES;  // Also in sleep
        else if (rst_cnt_ff != 4'h0)
            rst_cnt_ff <= rst_cnt_ff - 4'h1;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            chip_reset_req <= 1'b0;
        else
            chip_reset_req <= overflow || (rst_cnt_ff > 4'h1);
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            wd_running <= 1'b0;
        else
            wd_running <= running && !overflow;
    end

    // ------------------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------------------
    always_comb
    begin
        irq_evt                   = '0;
        irq_evt[`WDU_IRQ_REFRESH] = refresh_hit && running;
        irq_evt[`WDU_IRQ_KEY_ERR] = key_err;
        irq_evt[`WDU_IRQ_TIMEOUT] = overflow;
        nxt_irq_stat              = irq_stat_ff;
        if (wr_at(bus_req, `WDU_ADDR_IRQ_STATUS))
            nxt_irq_stat = nxt_irq_stat & ~bus_req.wdata[`WDU_IRQ_W-1:0];
        nxt_irq_stat = nxt_irq_stat | irq_evt;  // Set wins over clear
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            irq_stat_ff <= '0;
        else
            irq_stat_ff <= nxt_irq_stat;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            irq_mask_ff <= '0;
        else if (wr_at(bus_req, `WDU_ADDR_IRQ_MASK))
            irq_mask_ff <= bus_req.wdata[`WDU_IRQ_W-1:0];
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            irq <= 1'b0;
        else
            irq <= |(nxt_irq_stat & irq_mask_ff);
    end

    // ------------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------------
    always_comb
    begin
        nxt_rdata = `WDU_ZERO8;
        if (bus_req.re)
        begin
            unique case (bus_req.addr)
                `WDU_ADDR_RESET_CAUSE:
                    nxt_rdata[`WDU_CAUSE_FLAG_BIT] = flag_ff;
                `WDU_ADDR_CONTROL:
                begin
                    nxt_rdata[`WDU_CTRL_FLAG_BIT] = flag_ff;
                    nxt_rdata[`WDU_CTRL_EN_BIT]   = ctrl_ff.sw_en;
                    nxt_rdata[3:0]                = ctrl_ff.sel;
                end
                `WDU_ADDR_IRQ_STATUS:
                    nxt_rdata[`WDU_IRQ_W-1:0] = irq_stat_ff;
                `WDU_ADDR_IRQ_MASK:
                    nxt_rdata[`WDU_IRQ_W-1:0] = irq_mask_ff;
                `WDU_ADDR_COUNT:
                    nxt_rdata = cnt_ff;
                default:
                    nxt_rdata = `WDU_ZERO8;  // Key registers and holes read zero
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            rdata <= `WDU_ZERO8;
        else
            rdata <= nxt_rdata;
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_open;
        key_ff == wdu_pkg::KEY_GOT_SECOND && key_wr && bus_req.wdata == `WDU_KEY_THIRD;
    endsequence

    sequence s_locked_write;
        ctrl_wr && key_ff != wdu_pkg::KEY_OPEN && !overflow;
    endsequence

    sequence s_timeout;
        overflow;
    endsequence

    a_refresh_clears: assert property (refresh_hit |=> cnt_ff == 8'h00)
        else $error("refresh key did not clear counter");

    a_bad_refresh_ignored: assert property (
        wr_at(bus_req, `WDU_ADDR_REFRESH_KEY) && !refresh_hit && !counter_tick
        && running |=> $stable(cnt_ff))
        else $error("non-key refresh write changed counter");

    a_timeout_flag: assert property (s_timeout |=> flag_ff && !ctrl_ff.sw_en)
        else $error("time-out did not set flag and clear enable");

    a_reset_pulse: assert property (
        s_timeout |=> chip_reset_req [*4] ##1 !chip_reset_req)
        else $error("chip reset request not four cycles");

    a_no_sw_stop: assert property (
        running && !overflow |=> ctrl_ff.sw_en)
        else $error("started watchdog was stopped");

    a_locked_ctrl: assert property (s_locked_write |=> $stable(ctrl_ff))
        else $error("locked control register changed");

    a_unlock_seq: assert property (
        s_open and !overflow |=> key_ff == wdu_pkg::KEY_OPEN)
        else $error("complete key sequence did not unlock");

    a_strap_blocks: assert property (cfg_loaded_ff && cfg_dis_ff |-> cnt_ff == 8'h00)
        else $error("counter moved with disable strap set");

    a_flag_sticky: assert property (
        flag_ff && !wr_at(bus_req, `WDU_ADDR_RESET_CAUSE) |=> flag_ff)
        else $error("reset flag lost without software clear");

    a_tick_count: assert property (
        running && counter_tick && cnt_ff != `WDU_CNT_MAX && !refresh_hit
        |=> cnt_ff == $past(cnt_ff) + 8'h01)
        else $error("counter did not advance on tick");

endmodule : wdu_top

/* File: design/wdu_map.svh */
// Register map, field positions, reset values and timing counts of the watchdog unit.
// Assumes inclusion by bare name from every design file that needs a constant.
//
// Behaviour
// - An 8-bit up-counter whose overflow requests a reset of the whole chip.
// - Time base comes from the free-running 250 kHz oscillator, not the CPU clock.
// - An enabled time-out resets the chip both in normal and in sleep mode.
// - Counter clock is oscillator over 2**divider_select; time-out is 256 counter clocks.
// - Divider select resets to 0100b, about a 16.38 ms time-out.
// - Divider select sits in bits 3 to 0 of the control register.
// - Configuration disable bit sampled at reset; when 1 the watchdog never runs.
// - With disable bit 0, setting the software enable bit starts counting; bit is R/W.
// - Every reset, hardware or watchdog, clears the software enable bit.
// - External reset leaves the watchdog disabled and returns its registers to their reset values.
// - Once counting, software cannot stop the watchdog.
// - Writing 0x55 to the refresh key register clears the counter and restarts it.
// - Control register is read-only until keys 55h, AAh, 5Ah are written in order.
// - On overflow the reset flag is set, then the chip is reset.
// - Reset flag is bit 3 of reset cause; software or external reset clears it.
`ifndef WDU_MAP_SVH
`define WDU_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define WDU_ADDR_RESET_CAUSE  8'ha1
`define WDU_ADDR_CONTROL      8'hb6
`define WDU_ADDR_REFRESH_KEY  8'hb7
`define WDU_ADDR_ACCESS_KEY   8'hf7
`define WDU_ADDR_IRQ_STATUS   8'hc8
`define WDU_ADDR_IRQ_MASK     8'hc9
`define WDU_ADDR_COUNT        8'hca

// ----------------------------------------------------------------------------
// Fields, keys and reset values
// ----------------------------------------------------------------------------
`define WDU_CTRL_FLAG_BIT     7
`define WDU_CTRL_EN_BIT       5
`define WDU_CAUSE_FLAG_BIT    3
`define WDU_SEL_RESET         4'h4
`define WDU_REFRESH_KEY       8'h55
`define WDU_KEY_FIRST         8'h55
`define WDU_KEY_SECOND        8'haa
`define WDU_KEY_THIRD         8'h5a
`define WDU_ZERO8             8'h00
`define WDU_CNT_MAX           8'hff
`define WDU_IRQ_REFRESH       0
`define WDU_IRQ_KEY_ERR       1
`define WDU_IRQ_TIMEOUT       2
`define WDU_IRQ_W             3

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define WDU_REF_HZ            50000000
`define WDU_RC_HZ             250000
`define WDU_RC_DIV            (`WDU_REF_HZ / `WDU_RC_HZ)
`define WDU_RST_CYCLES        4'h4
`define WDU_DIV_W             15

`endif

/* File: design/wdu_pkg.sv */
// Types shared by the watchdog unit modules.
// Assumes the map header supplies the numeric constants.
`include "wdu_map.svh"

package wdu_pkg;

    // ------------------------------------------------------------------------
    // Register bus request
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       we;
        logic       re;
    } wdu_bus_req_t;

    // ------------------------------------------------------------------------
    // Control register contents held in flops
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic       sw_en;
        logic [3:0] sel;
    } wdu_ctrl_t;

    // Unlock sequence progress
    typedef enum logic [1:0] {
        KEY_IDLE,
        KEY_GOT_FIRST,
        KEY_GOT_SECOND,
        KEY_OPEN
    } wdu_key_state_t;

endpackage : wdu_pkg

/* File: design/wdu_prescaler.sv */
// Oscillator time base and power-of-two divider of the watchdog unit.
// Assumes ref_clk is always running and one pulse out means one counter clock.
`timescale 1ns/1ps
`include "wdu_map.svh"

module wdu_prescaler (
    input  wire logic       ref_clk,      // Always-on clock
    input  wire logic       rst,          // Async reset, active high
    input  wire logic [3:0] sel,          // Divider select
    input  wire logic       restart,      // Clear divider chain
    output logic            counter_tick  // One pulse per counter clock
);

    logic [7:0]            osc_cnt_ff;
    logic                  osc_tick;
    logic [`WDU_DIV_W-1:0] div_ff;
    logic [`WDU_DIV_W-1:0] div_mask;

    // Mask of low divider bits that must all be set
    function automatic logic [`WDU_DIV_W-1:0] sel_mask(input logic [3:0] s);
        sel_mask = `WDU_DIV_W'((32'h1 << s) - 32'h1);
    endfunction : sel_mask

    assign osc_tick = (osc_cnt_ff == 8'(`WDU_RC_DIV - 1));
    assign div_mask = sel_mask(sel);

    // ------------------------------------------------------------------------
    // Free-running oscillator time base
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            osc_cnt_ff <= 8'h00;
        else if (osc_tick)
            osc_cnt_ff <= 8'h00;
        else
            osc_cnt_ff <= osc_cnt_ff + 8'h01;  // Runs regardless of CPU clock
    end

    // Power-of-two divider chain
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            div_ff <= '0;
        else if (restart)
            div_ff <= '0;
        else if (osc_tick)
            div_ff <= div_ff + `WDU_DIV_W'(1);
    end

    // Tick when low sel bits roll over
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            counter_tick <= 1'b0;
        else
            counter_tick <= osc_tick && !restart && ((div_ff & div_mask) == div_mask);
    end

endmodule : wdu_prescaler

/* File: sim/watchdog_timer_unit_tb.sv */
// Self-checking bench of the watchdog unit top level.
// Assumes the map header constants and a single-cycle register port master.
`timescale 1ns/1ps
`include "wdu_map.svh"

module watchdog_timer_unit_tb;

    // ------------------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------------------
    logic                  ref_clk  = 1'b0;
    logic                  rst      = 1'b1;
    logic                  strap    = 1'b0;
    wdu_pkg::wdu_bus_req_t bus_req  = '0;
    logic [7:0]            rdata;
    logic                  chip_reset_req;
    logic                  wd_running;
    logic                  irq;
    integer                miscompares = 0;
    integer                check_count = 0;
    integer                seed = 32'he47e0963;
    integer                n;
    integer                m;
    logic [7:0]            v;
    logic [7:0]            m_ctrl;

    // Free-running 50 MHz clock
    always #10 ref_clk = ~ref_clk;

    wdu_top dut_u (
        .ref_clk            (ref_clk),
        .rst                (rst),
        .config_disable_bit (strap),
        .bus_req            (bus_req),
        .rdata              (rdata),
        .chip_reset_req     (chip_reset_req),
        .wd_running         (wd_running),
        .irq                (irq)
    );

    // ------------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------------
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // One-cycle write strobe
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus_req <= {a, d, 2'b10};
        @(posedge ref_clk);
        bus_req <= '0;
    endtask : wr

    // One-cycle read strobe, data sampled in the cycle after
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        bus_req <= {a, 8'h00, 2'b01};
        @(posedge ref_clk);
        bus_req <= '0;
        #1 d = rdata;
    endtask : rd

    task unlock;
        wr(`WDU_ADDR_ACCESS_KEY, `WDU_KEY_FIRST);
        wr(`WDU_ADDR_ACCESS_KEY, `WDU_KEY_SECOND);
        wr(`WDU_ADDR_ACCESS_KEY, `WDU_KEY_THIRD);
    endtask : unlock

    task do_reset(input logic s);
        rst   <= 1'b1;
        strap <= s;
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
    endtask : do_reset

    task tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish

    // Hang guard, well past one full time-out at the shortest select
    initial
    begin
        #(20 * 150000);
        miscompares++;
        tally_and_finish();
    end

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial
    begin
        do_reset(1'b0);
        m_ctrl = {2'b00, 1'b0, 1'b0, `WDU_SEL_RESET};
        rd(`WDU_ADDR_CONTROL, v);     chk(v, m_ctrl);
        rd(`WDU_ADDR_RESET_CAUSE, v); chk(v, 8'h00);
        chk({7'h0, wd_running}, 8'h00);
        // Locked write, then a broken key order, are both ignored
        wr(`WDU_ADDR_CONTROL, $random(seed) | 8'h20);
        rd(`WDU_ADDR_CONTROL, v);     chk(v, m_ctrl);
        wr(`WDU_ADDR_ACCESS_KEY, `WDU_KEY_FIRST);
        wr(`WDU_ADDR_ACCESS_KEY, `WDU_KEY_THIRD);
        wr(`WDU_ADDR_CONTROL, 8'h20);
        rd(`WDU_ADDR_CONTROL, v);     chk(v, m_ctrl);
        // Full sequence: enable with the shortest select
        unlock();
        m_ctrl = 8'h20;
        wr(`WDU_ADDR_CONTROL, m_ctrl);
        rd(`WDU_ADDR_CONTROL, v);     chk(v, m_ctrl);
        chk({7'h0, wd_running}, 8'h01);
        // Software cannot stop a running counter
        unlock();
        wr(`WDU_ADDR_CONTROL, 8'h00);
        rd(`WDU_ADDR_CONTROL, v);     chk(v & 8'h20, 8'h20);
        chk({7'h0, wd_running}, 8'h01);
        // Wrong refresh value leaves the count, right one clears it
        repeat (1000) @(posedge ref_clk);
        rd(`WDU_ADDR_COUNT, v);
        n = v;
        v = $random(seed);
        if (v == `WDU_REFRESH_KEY)
            v = 8'h56;
        wr(`WDU_ADDR_REFRESH_KEY, v);
        rd(`WDU_ADDR_COUNT, v);       chk({7'h0, v >= 8'(n) && v != 8'h00}, 8'h01);
        wr(`WDU_ADDR_REFRESH_KEY, `WDU_REFRESH_KEY);
        rd(`WDU_ADDR_COUNT, v);       chk(v, 8'h00);
        // Time-out: 256 ticks of 200 cycles each at select 0
        wr(`WDU_ADDR_IRQ_MASK, 8'h04);
        n = 0;
        while (chip_reset_req !== 1'b1 && n < 60000)
        begin
            @(posedge ref_clk);
            #1 n++;
        end
        chk({7'h0, n > 51000 && n < 51400}, 8'h01);
        m = 0;
        while (chip_reset_req === 1'b1 && m < 10)
        begin
            @(posedge ref_clk);
            #1 m++;
        end
        chk(8'(m), 8'h04);
        rd(`WDU_ADDR_RESET_CAUSE, v); chk(v, 8'h08);
        rd(`WDU_ADDR_CONTROL, v);     chk(v & 8'h7f, 8'h04);
        chk({6'h0, wd_running, irq}, 8'h01);
        // Interrupt status clear, then reset flag clear by software
        wr(`WDU_ADDR_IRQ_STATUS, 8'h04);
        @(posedge ref_clk);
        #1 chk({7'h0, irq}, 8'h00);
        wr(`WDU_ADDR_RESET_CAUSE, 8'h08);
        rd(`WDU_ADDR_RESET_CAUSE, v); chk(v, 8'h00);
        // Strap set: enable has no effect
        do_reset(1'b1);
        unlock();
        wr(`WDU_ADDR_CONTROL, 8'h20);
        repeat (4) @(posedge ref_clk);
        #1 chk({7'h0, wd_running}, 8'h00);
        tally_and_finish();
    end

endmodule : watchdog_timer_unit_tb
